// file: rtl/pls_map.svh
// Constants for the pressure-loop supervisor: timing, scaling, field positions
`ifndef PLS_MAP_SVH
`define PLS_MAP_SVH

// ****************************************************************
// Clock and time base
// ****************************************************************
`define PLS_CLK_PERIOD_NS 4
`define PLS_MS_NS 1000000
`define PLS_TENTH_S_MS 100

// ****************************************************************
// Scaling: pressure and speed in 0.1 %, gains in 0.001
// ****************************************************************
`define PLS_FULL_SCALE 16'sh03E8
`define PLS_GAIN_SCALE 48'sh0000000003E8
`define PLS_INTEG_LIMIT 48'sh00003B9ACA00
`define PLS_OUT_MAX 48'sh000000007FFF
`define PLS_OUT_MIN -48'sh000000008000

// ****************************************************************
// Fault action select fields and codes
// ****************************************************************
`define PLS_SENSOR_ACT_LSB 0
`define PLS_UNLOAD_ACT_LSB 4
`define PLS_ACT_W 4
`define PLS_ACT_SILENT 4'h0
`define PLS_ACT_ALARM 4'h1
`define PLS_ACT_STOP 4'h2

// ****************************************************************
// Reset values
// ****************************************************************
`define PLS_ZERO16 16'sh0000
`define PLS_ZERO32 32'h0000_0000
`define PLS_ZERO48 48'sh000000000000

`endif

// file: rtl/pls_pkg.sv
// Types shared by the pressure-loop supervisor files
package pls_pkg;

    // One PID gain set, each gain in units of 0.001
    typedef struct packed {
        logic [15:0] prop;
        logic [15:0] integ;
        logic [15:0] deriv;
    } pls_gains_t;

    // One overshoot-suppression setting: level in 0.1 %, coefficient plain
    typedef struct packed {
        logic [15:0] level;
        logic [7:0] coeff;
    } pls_overshoot_t;

    // Decoded fault action
    typedef enum logic [1:0] {
        PLS_SILENT,
        PLS_ALARM,
        PLS_STOP
    } pls_action_t;

    // Fault report for one fault source
    typedef struct packed {
        logic alarm;
        logic error;
    } pls_report_t;

endpackage

// file: rtl/pls_qual_timer.sv
// Millisecond qualifying timer: expires once a condition has held longer than a limit
`timescale 1ns/1ps
`include "pls_map.svh"

module pls_qual_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Time base and qualifier
    input wire logic msTick,
    input wire logic cond,
    input wire logic [31:0] limitMs,
    // Result
    output logic expired
);

    logic [31:0] count_q, count_d;
    logic expired_q, expired_d;

    // ****************************************************************
    // Counting
    // ****************************************************************
    always_comb begin
        count_d = count_q;
        if (!cond) begin
            count_d = `PLS_ZERO32;
        end else if (msTick && count_q <= limitMs) begin
            // Saturates just past the limit so the counter cannot wrap
            count_d = count_q + 32'h0000_0001;
        end
        expired_d = cond && (count_d > limitMs);
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            count_q <= `PLS_ZERO32;
            expired_q <= 1'b0;
        end else begin
            count_q <= count_d;
            expired_q <= expired_d;
        end
    end

    assign expired = expired_q;

endmodule

// file: rtl/pls_supervisor.sv
// Pressure-loop supervisor: reference ramp, gain selection, PID, sensor faults, hold state
`timescale 1ns/1ps
`include "pls_map.svh"

// Behaviour
// - The reference slews toward its target at a constant rate so a full-scale step takes the rise time.
// - The pressure correction is a PID law on the first gain set, or on the second while useGainSetB is set and the gain-switch terminal is not active.
// - A second, separately settable PID gain set is held.
// - While the gain-switch terminal is active the third gain set drives the loop.
// - While the gain-switch terminal is active the ramp uses the alternate rise time.
// - While the gain-switch terminal is active the second overshoot level and coefficient are used.
// - The low digit of the fault action decides sensor faults: silent, alarm, or coast with error.
// - The high digit decides the unloading reverse-speed-limit fault in the same way.
// - The feedback-lost and over-range outputs follow the sensor faults whatever the action.
// - Feedback is lost when it stays below the loss threshold longer than the loss time.
// - Feedback is over-range when it stays above the over-range threshold longer than its time.
// - Holding state is output once error and speed are small and the delay has passed.
// - While the speed-mode terminal is active torque is capped at the speed-mode limit.
// - Reverse speed during unloading is limited to the set fraction of maximum speed.
module pls_supervisor #(
    parameter int MS_CYCLES = `PLS_MS_NS / `PLS_CLK_PERIOD_NS
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Terminal functions and run state
    input wire logic gainSwitchActive,
    input wire logic speedModeActive,
    input wire logic unloadActive,
    input wire logic faultClear,
    // Process values, 0.1 % units, signed except normalTorqueLimit
    input wire logic signed [15:0] pressureTarget,
    input wire logic signed [15:0] pressureFeedback,
    input wire logic signed [15:0] motorSpeed,
    input wire logic [15:0] normalTorqueLimit,
    // Loop settings
    input wire logic [15:0] reference_rise_time,
    input wire logic [15:0] alternate_rise_time,
    input wire pls_pkg::pls_gains_t gainSetA,
    input wire pls_pkg::pls_gains_t gainSetB,
    input wire pls_pkg::pls_gains_t gainSetC,
    input wire logic useGainSetB,
    input wire pls_pkg::pls_overshoot_t overshootA,
    input wire pls_pkg::pls_overshoot_t overshootB,
    // Fault and state settings
    input wire logic [7:0] fault_action_select,
    input wire logic signed [15:0] loss_threshold,
    input wire logic [15:0] loss_detect_time,
    input wire logic signed [15:0] overrange_threshold,
    input wire logic [15:0] overrange_detect_time,
    input wire logic signed [15:0] unload_reverse_speed_cap,
    input wire logic [15:0] hold_state_speed_max,
    input wire logic [15:0] hold_state_error_max,
    input wire logic [15:0] hold_state_delay,
    input wire logic [15:0] speed_mode_torque_cap,
    // Loop outputs
    output logic signed [15:0] pressureReference,
    output logic signed [15:0] pressureCorrection,
    output pls_pkg::pls_overshoot_t activeOvershoot,
    output logic [15:0] torqueLimit,
    output logic signed [15:0] reverseSpeedLimit,
    // Fault and state outputs
    output logic feedbackLostOut,
    output logic feedbackOverrangeOut,
    output pls_pkg::pls_report_t lostReport,
    output pls_pkg::pls_report_t overrangeReport,
    output pls_pkg::pls_report_t unloadReport,
    output logic coastStop,
    output logic holdingPressure
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic pls_pkg::pls_action_t decodeAction(input logic [3:0] digit);
        unique case (digit)
            `PLS_ACT_SILENT: decodeAction = pls_pkg::PLS_SILENT;
            `PLS_ACT_ALARM: decodeAction = pls_pkg::PLS_ALARM;
            // Undefined digits stop the drive: the safe reading of a bad setting
            default: decodeAction = pls_pkg::PLS_STOP;
        endcase
    endfunction

    function automatic logic [15:0] absVal(input logic signed [15:0] v);
        absVal = (v < 0) ? 16'(-v) : 16'(v);
    endfunction

    // ****************************************************************
    // Millisecond tick
    // ****************************************************************
    logic [31:0] prescale_q, prescale_d;
    logic msTick_q, msTick_d;

    always_comb begin
        prescale_d = prescale_q + 32'h0000_0001;
        msTick_d = 1'b0;
        if (prescale_q >= 32'(MS_CYCLES - 1)) begin
            prescale_d = `PLS_ZERO32;
            msTick_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prescale_q <= `PLS_ZERO32;
            msTick_q <= 1'b0;
        end else begin
            prescale_q <= prescale_d;
            msTick_q <= msTick_d;
        end
    end

    // ****************************************************************
    // Setting selection
    // ****************************************************************
    logic [15:0] riseTime;
    pls_pkg::pls_gains_t gains;

    always_comb begin
        riseTime = gainSwitchActive ? alternate_rise_time : reference_rise_time;
        if (gainSwitchActive) begin
            gains = gainSetC;
        end else if (useGainSetB) begin
            gains = gainSetB;
        end else begin
            gains = gainSetA;
        end
    end

    // ****************************************************************
    // Reference ramp
    // ****************************************************************
    // One unit step per crossing keeps the rate exact without a divider
    logic signed [15:0] ref_q, ref_d;
    logic [31:0] rampAcc_q, rampAcc_d;

    always_comb begin
        ref_d = ref_q;
        rampAcc_d = rampAcc_q;
        if (riseTime == 16'h0000 || ref_q == pressureTarget) begin
            ref_d = pressureTarget;
            rampAcc_d = `PLS_ZERO32;
        end else begin
            if (msTick_q) begin
                rampAcc_d = rampAcc_q + 32'(`PLS_FULL_SCALE);
            end
            if (rampAcc_q >= 32'(riseTime)) begin
                rampAcc_d = rampAcc_d - 32'(riseTime);
                ref_d = (ref_q < pressureTarget) ? ref_q + 16'sh0001 : ref_q - 16'sh0001;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ref_q <= `PLS_ZERO16;
            rampAcc_q <= `PLS_ZERO32;
        end else begin
            ref_q <= ref_d;
            rampAcc_q <= rampAcc_d;
        end
    end

    // ****************************************************************
    // PID, updated once per millisecond
    // ****************************************************************
    logic signed [15:0] prevErr_q, prevErr_d, corr_q, corr_d;
    logic signed [47:0] integ_q, integ_d;
    logic signed [47:0] err, pTerm, dTerm, sum;

    always_comb begin
        err = 48'(ref_q - pressureFeedback);
        pTerm = err * $signed({32'h0000_0000, gains.prop});
        dTerm = 48'(ref_q - pressureFeedback - prevErr_q) * $signed({32'h0000_0000, gains.deriv});
        integ_d = integ_q;
        prevErr_d = prevErr_q;
        corr_d = corr_q;
        sum = `PLS_ZERO48;
        if (msTick_q) begin
            integ_d = integ_q + err * $signed({32'h0000_0000, gains.integ});
            // Clamp holds the integrator within +/-PLS_INTEG_LIMIT, far past the level that saturates the output
            if (integ_d > `PLS_INTEG_LIMIT) begin
                integ_d = `PLS_INTEG_LIMIT;
            end else if (integ_d < -`PLS_INTEG_LIMIT) begin
                integ_d = -`PLS_INTEG_LIMIT;
            end
            sum = (pTerm + integ_d + dTerm) / `PLS_GAIN_SCALE;
            if (sum > `PLS_OUT_MAX) begin
                sum = `PLS_OUT_MAX;
            end else if (sum < `PLS_OUT_MIN) begin
                sum = `PLS_OUT_MIN;
            end
            corr_d = sum[15:0];
            prevErr_d = err[15:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            integ_q <= `PLS_ZERO48;
            prevErr_q <= `PLS_ZERO16;
            corr_q <= `PLS_ZERO16;
        end else begin
            integ_q <= integ_d;
            prevErr_q <= prevErr_d;
            corr_q <= corr_d;
        end
    end

    // ****************************************************************
    // Qualifying timers
    // ****************************************************************
    logic lostExp, overExp, holdExp;
    logic holdCond;

    assign holdCond = (absVal(16'(pressureFeedback - ref_q)) < hold_state_error_max)
        && (absVal(motorSpeed) < hold_state_speed_max);

    pls_qual_timer lostTimer (
        .clk(clk),
        .reset_n(reset_n),
        .msTick(msTick_q),
        .cond(pressureFeedback < loss_threshold),
        .limitMs(32'(loss_detect_time) * 32'(`PLS_TENTH_S_MS)),
        .expired(lostExp)
    );

    pls_qual_timer overTimer (
        .clk(clk),
        .reset_n(reset_n),
        .msTick(msTick_q),
        .cond(pressureFeedback > overrange_threshold),
        .limitMs(32'(overrange_detect_time) * 32'(`PLS_TENTH_S_MS)),
        .expired(overExp)
    );

    pls_qual_timer holdTimer (
        .clk(clk),
        .reset_n(reset_n),
        .msTick(msTick_q),
        .cond(holdCond),
        .limitMs(32'(hold_state_delay)),
        .expired(holdExp)
    );

    // ****************************************************************
    // Fault handling and outputs
    // ****************************************************************
    // Alarms follow the fault; errors latch until cleared and set wins over clear
    pls_pkg::pls_action_t sensorAct, unloadAct;
    logic unloadFault;
    pls_pkg::pls_report_t lost_q, lost_d, over_q, over_d, unl_q, unl_d;
    logic lostOut_q, overOut_q, coast_q, coast_d, hold_q;
    logic [15:0] torque_q, torque_d;
    logic signed [15:0] revCap_q;

    always_comb begin
        sensorAct = decodeAction(fault_action_select[`PLS_SENSOR_ACT_LSB +: `PLS_ACT_W]);
        unloadAct = decodeAction(fault_action_select[`PLS_UNLOAD_ACT_LSB +: `PLS_ACT_W]);
        unloadFault = unloadActive && (motorSpeed < unload_reverse_speed_cap);
        lost_d.alarm = lostExp && (sensorAct == pls_pkg::PLS_ALARM);
        over_d.alarm = overExp && (sensorAct == pls_pkg::PLS_ALARM);
        unl_d.alarm = unloadFault && (unloadAct == pls_pkg::PLS_ALARM);
        lost_d.error = (lostExp && sensorAct == pls_pkg::PLS_STOP) || (lost_q.error && !faultClear);
        over_d.error = (overExp && sensorAct == pls_pkg::PLS_STOP) || (over_q.error && !faultClear);
        unl_d.error = (unloadFault && unloadAct == pls_pkg::PLS_STOP)
            || (unl_q.error && !faultClear);
        coast_d = lost_d.error || over_d.error || unl_d.error;
        torque_d = speedModeActive ? speed_mode_torque_cap : normalTorqueLimit;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lost_q <= '0;
            over_q <= '0;
            unl_q <= '0;
            lostOut_q <= 1'b0;
            overOut_q <= 1'b0;
            coast_q <= 1'b0;
            hold_q <= 1'b0;
            torque_q <= 16'(`PLS_ZERO16);
            revCap_q <= `PLS_ZERO16;
        end else begin
            lost_q <= lost_d;
            over_q <= over_d;
            unl_q <= unl_d;
            lostOut_q <= lostExp;
            overOut_q <= overExp;
            coast_q <= coast_d;
            hold_q <= holdExp;
            torque_q <= torque_d;
            revCap_q <= unload_reverse_speed_cap;
        end
    end

    // Overshoot setting is registered, so it follows the gain switch one cycle later
    pls_pkg::pls_overshoot_t osh_q;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            osh_q <= '0;
        end else begin
            osh_q <= gainSwitchActive ? overshootB : overshootA;
        end
    end

    assign pressureReference = ref_q;
    assign pressureCorrection = corr_q;
    assign activeOvershoot = osh_q;
    assign torqueLimit = torque_q;
    assign reverseSpeedLimit = revCap_q;
    assign feedbackLostOut = lostOut_q;
    assign feedbackOverrangeOut = overOut_q;
    assign lostReport = lost_q;
    assign overrangeReport = over_q;
    assign unloadReport = unl_q;
    assign coastStop = coast_q;
    assign holdingPressure = hold_q;

endmodule

// file: test/pls_supervisor_properties.sv
// Port checker for the pressure-loop supervisor
`timescale 1ns/1ps
module pls_supervisor_properties #(
    parameter int MS_CYCLES = 10
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic gainSwitchActive,
    input wire logic speedModeActive,
    input wire logic faultClear,
    input wire logic signed [15:0] pressureFeedback,
    input wire logic [15:0] normalTorqueLimit,
    input wire logic [15:0] reference_rise_time,
    input wire pls_pkg::pls_overshoot_t overshootA,
    input wire pls_pkg::pls_overshoot_t overshootB,
    input wire logic [7:0] fault_action_select,
    input wire logic signed [15:0] loss_threshold,
    input wire logic [15:0] loss_detect_time,
    input wire logic signed [15:0] unload_reverse_speed_cap,
    input wire logic [15:0] speed_mode_torque_cap,
    input wire logic signed [15:0] pressureReference,
    input wire pls_pkg::pls_overshoot_t activeOvershoot,
    input wire logic [15:0] torqueLimit,
    input wire logic signed [15:0] reverseSpeedLimit,
    input wire logic feedbackLostOut,
    input wire pls_pkg::pls_report_t lostReport,
    input wire pls_pkg::pls_report_t overrangeReport,
    input wire pls_pkg::pls_report_t unloadReport,
    input wire logic coastStop,
    input wire logic holdingPressure
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // ****
    // Helper logic
    // ****
    // Run length is cleared on any dip, so a design that misses a dip fails
    logic [31:0] lowRun_q, lowRun_d, lossLimit;
    logic liveQ_q, liveQ_d, lowFb;
    assign lowFb = pressureFeedback < loss_threshold;
    assign lossLimit = 32'(loss_detect_time) * 32'd100 * 32'(MS_CYCLES);
    always_comb begin
        liveQ_d = reset_n;
        lowRun_d = (reset_n && lowFb) ? lowRun_q + 32'h1 : 32'h0;
    end
    always_ff @(posedge clk) begin
        liveQ_q <= liveQ_d;
        lowRun_q <= lowRun_d;
    end
    // ****
    // Assertions
    // ****
    a_torque_speed_cap: assert property (liveQ_q && speedModeActive |=> torqueLimit == $past(speed_mode_torque_cap))
        else $error("torque cap missing in speed mode");
    a_torque_normal: assert property (liveQ_q && !speedModeActive |=> torqueLimit == $past(normalTorqueLimit))
        else $error("normal torque limit not used");
    a_overshoot_alt: assert property (liveQ_q && gainSwitchActive |=> activeOvershoot == $past(overshootB))
        else $error("second overshoot set not used");
    a_overshoot_primary: assert property (liveQ_q && !gainSwitchActive |=> activeOvershoot == $past(overshootA))
        else $error("first overshoot set not used");
    a_reverse_cap: assert property (liveQ_q |=> reverseSpeedLimit == $past(unload_reverse_speed_cap))
        else $error("reverse speed limit wrong");
    a_ramp_rate: assert property ((liveQ_q && reference_rise_time == 16'h03E8 && !gainSwitchActive) [*2] |-> (pressureReference - $past(pressureReference)) inside {16'sh0001, 16'sh0000, 16'shFFFF})
        else $error("reference slews too fast");
    a_silent_quiet: assert property ((fault_action_select == 8'h00) [*3] |-> !(lostReport.alarm || overrangeReport.alarm || unloadReport.alarm))
        else $error("alarm raised with silent action");
    a_error_coasts: assert property (lostReport.error || overrangeReport.error || unloadReport.error |-> coastStop)
        else $error("error without coast stop");
    a_error_clear: assert property (liveQ_q && $fell(lostReport.error) |-> $past(faultClear) || $past(faultClear, 2))
        else $error("error dropped without clear");
    a_lost_time: assert property ($rose(feedbackLostOut) |-> lowRun_q > lossLimit)
        else $error("feedback lost declared early");
    a_lost_drop: assert property (!lowFb [*4] |-> !feedbackLostOut)
        else $error("feedback lost output stuck");
    c_lost_error: cover property (lostReport.error);
    c_unload_alarm: cover property (unloadReport.alarm);
    c_hold: cover property ($rose(holdingPressure));
    c_speed_mode: cover property (liveQ_q && speedModeActive);
endmodule

bind pls_supervisor pls_supervisor_properties #(.MS_CYCLES(MS_CYCLES)) props_u (.*);

// file: test/pls_far_side.sv
// Far-side model: pressure sensor and motor speed loop
`timescale 1ns/1ps
module pls_far_side (
    // Clock and commands
    input wire logic clk,
    input wire logic slow,
    input wire logic signed [15:0] fbCmd,
    input wire logic signed [15:0] spdCmd,
    // Sensed values
    output logic signed [15:0] pressureFeedback,
    output logic signed [15:0] motorSpeed
);
    // Slow mode mimics a sluggish hydraulic response, one unit per clock
    always @(posedge clk) begin
        motorSpeed <= spdCmd;
        if (!slow || pressureFeedback == fbCmd) begin
            pressureFeedback <= fbCmd;
        end else if (pressureFeedback < fbCmd) begin
            pressureFeedback <= pressureFeedback + 16'sh0001;
        end else begin
            pressureFeedback <= pressureFeedback - 16'sh0001;
        end
    end
endmodule

// file: test/test_pls_supervisor.sv
// Self-checking bench for the pressure-loop supervisor
`timescale 1ns/1ps
module test_pls_supervisor;
    logic clk, reset_n, gainSwitchActive, speedModeActive, unloadActive, faultClear, useGainSetB;
    logic slow, feedbackLostOut, feedbackOverrangeOut, coastStop, holdingPressure;
    logic signed [15:0] pressureTarget, pressureFeedback, motorSpeed, fbCmd, spdCmd;
    logic signed [15:0] loss_threshold, overrange_threshold, unload_reverse_speed_cap;
    logic signed [15:0] pressureReference, pressureCorrection, reverseSpeedLimit;
    logic [15:0] normalTorqueLimit, reference_rise_time, alternate_rise_time, loss_detect_time;
    logic [15:0] overrange_detect_time, hold_state_speed_max, hold_state_error_max;
    logic [15:0] hold_state_delay, speed_mode_torque_cap, torqueLimit;
    logic [7:0] fault_action_select;
    pls_pkg::pls_gains_t gainSetA, gainSetB, gainSetC;
    pls_pkg::pls_overshoot_t overshootA, overshootB, activeOvershoot;
    pls_pkg::pls_report_t lostReport, overrangeReport, unloadReport;
    int err_total = 0;
    int checks = 0;
    int cyc = 0;
    int n;

    // Short millisecond so the detection times fit the run
    pls_supervisor #(.MS_CYCLES(10)) dut_u (.*);
    pls_far_side far_u (.*);

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    // ****
    // Shared tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return feedbackLostOut;
            1: return feedbackOverrangeOut;
            2: return unloadReport.alarm;
            3: return unloadReport.error;
            default: return holdingPressure;
        endcase
    endfunction
    task automatic waitFor(input int s, input int lim);
        n = 0;
        while (pick(s) !== 1'b1 && n < lim) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task automatic testSelect();
        for (int i = 0; i < 4; i++) begin
            {speedModeActive, gainSwitchActive} = 2'(i);
            repeat (2) @(negedge clk);
            chk(activeOvershoot, i[0] ? overshootB : overshootA);
            chk(torqueLimit, i[1] ? speed_mode_torque_cap : normalTorqueLimit);
            chk(reverseSpeedLimit, unload_reverse_speed_cap);
        end
        {speedModeActive, gainSwitchActive} = 2'b00;
    endtask
    task automatic testRampPid();
        pressureTarget = 16'sh0064;
        repeat (500) @(negedge clk);
        chk(pressureReference >= 16'sh0030 && pressureReference <= 16'sh0034, 1'b1);
        gainSwitchActive = 1'b1;
        repeat (3) @(negedge clk);
        chk(pressureReference, 16'sh0064);
        gainSwitchActive = 1'b0;
        repeat (30) @(negedge clk);
        chk(pressureCorrection, 16'sh003C);
        useGainSetB = 1'b1;
        repeat (30) @(negedge clk);
        chk(pressureCorrection, 16'sh0078);
        gainSwitchActive = 1'b1;
        repeat (30) @(negedge clk);
        chk(pressureCorrection, 16'sh00B4);
        {gainSwitchActive, useGainSetB} = 2'b00;
    endtask
    task automatic testLoss();
        for (int a = 0; a < 3; a++) begin
            fault_action_select = 8'(a);
            fbCmd = -16'sh000A;
            waitFor(0, 100);
            repeat (2) @(negedge clk);
            chk(feedbackLostOut, 1'b1);
            chk(lostReport.alarm, a == 1);
            chk(coastStop, a == 2);
            faultClear = 1'b1;
            repeat (2) @(negedge clk);
            chk(lostReport.error, a == 2);
            {faultClear, slow} = 2'b01;
            fbCmd = 16'sh0028;
            repeat (80) @(negedge clk);
            chk(feedbackLostOut, 1'b0);
            chk(coastStop, a == 2);
            {faultClear, slow} = 2'b10;
            repeat (3) @(negedge clk);
            faultClear = 1'b0;
            chk(coastStop, 1'b0);
        end
    endtask
    task automatic testOverrange();
        fault_action_select = 8'h01;
        fbCmd = 16'sh03B6;
        repeat (900) @(negedge clk);
        fbCmd = 16'sh0064;
        repeat (50) @(negedge clk);
        fbCmd = 16'sh03B6;
        repeat (900) @(negedge clk);
        chk(feedbackOverrangeOut, 1'b0);
        waitFor(1, 400);
        chk(n >= 95 && n <= 125, 1'b1);
        chk(overrangeReport.alarm, 1'b1);
        fbCmd = 16'sh0028;
        fault_action_select = 8'h00;
        repeat (5) @(negedge clk);
        chk(overrangeReport.alarm, 1'b0);
    endtask
    task automatic testUnloadHold();
        {unloadActive, spdCmd, fault_action_select} = {1'b1, -16'sh00C8, 8'h10};
        waitFor(2, 40);
        chk(coastStop, 1'b0);
        fault_action_select = 8'h20;
        waitFor(3, 40);
        repeat (2) @(negedge clk);
        chk({unloadReport.alarm, coastStop}, 2'b01);
        {unloadActive, spdCmd, faultClear} = {1'b0, 16'sh0000, 1'b1};
        repeat (3) @(negedge clk);
        faultClear = 1'b0;
        repeat (2) @(negedge clk);
        chk(unloadReport.error, 1'b0);
        fault_action_select = 8'h00;
        fbCmd = 16'sh0064;
        waitFor(4, 200);
        chk(n >= 40 && n <= 75, 1'b1);
        spdCmd = 16'sh00C8;
        repeat (4) @(negedge clk);
        chk(holdingPressure, 1'b0);
    endtask

    initial begin
        {reset_n, gainSwitchActive, speedModeActive, unloadActive, faultClear} = '0;
        {useGainSetB, slow, pressureTarget, spdCmd, loss_threshold} = '0;
        {fbCmd, overrange_threshold, unload_reverse_speed_cap} = {16'sh0028, 16'sh0384, -16'sh0064};
        {reference_rise_time, alternate_rise_time} = {16'h03E8, 16'h0000};
        {loss_detect_time, overrange_detect_time} = {16'h0000, 16'h0001};
        {hold_state_speed_max, hold_state_error_max, hold_state_delay} = {16'h0064, 16'h0032, 16'h0005};
        {normalTorqueLimit, speed_mode_torque_cap, fault_action_select} = {16'h03E8, 16'h05DC, 8'h00};
        gainSetA = {16'h03E8, 16'h0000, 16'h0000};
        gainSetB = {16'h07D0, 16'h0000, 16'h0000};
        gainSetC = {16'h0BB8, 16'h0000, 16'h0000};
        overshootA = {16'h000A, 8'h03};
        overshootB = {16'h0005, 8'h05};
        repeat (12) @(negedge clk);
        chk({pressureReference, torqueLimit}, 32'h0000_0000);
        chk(coastStop, 1'b0);
        reset_n = 1'b1;
        testSelect();
        testRampPid();
        testLoss();
        testOverrange();
        testUnloadHold();
        print_verdict();
    end
endmodule
